//--- rtl/vsp_avg_if.sv
`timescale 1ns/1ps
`default_nettype none

// Threshold out to the averager, period results back to the register core
interface vsp_avg_if;
  logic [11:0] thr; // Threshold in sense codes
  logic done; // One-cycle pulse at the end of each period
  logic over; // Period average was strictly above threshold

  modport core (output thr, input done, input over);
  modport avg (input thr, output done, output over);
endinterface

`default_nettype wire

//--- rtl/vsp_core.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Setpoint code is linear output target scale
// - Code 0xA5 is nominal; reset default
// - Setpoint writes land only in shadow
// - Commit bit copies shadow into active setpoint
// - Limit field bits 7:3 sets threshold
// - Threshold is (89 + code)/128 full scale
// - Period average strictly above threshold exceeds
// - Flag needs all configured consecutive periods
// - Bits 1:0 choose one to four periods
module vsp_core #(
  parameter int PERIOD_CYCLES = vsp_pkg::OV_PERIOD_CYC // Clocks per averaging window
) (
  input wire logic ref_clk, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, held until next read
  input wire logic [11:0] local_sense_raw, // Local sense sample
  input wire logic local_sense_raw_valid, // Sample strobe
  output logic [7:0] active_setpoint, // Setpoint used by regulation
  output logic [11:0] ov_threshold, // Local overvoltage threshold code
  output logic ov_flag // Local overvoltage flag
);

  typedef struct packed {
    logic [7:0] shadow; // Software-visible setpoint copy
    logic [7:0] active; // Setpoint in use by regulation
    logic [7:0] limit; // Overvoltage limit register
    logic [11:0] thr; // Decoded threshold
    logic [2:0] run; // Consecutive exceeding periods
    vsp_pkg::vsp_ov_state_t st; // Qualifier state
    logic flag; // Overvoltage flag
    logic [7:0] rdata; // Read data register
  } vsp_core_state_t;

  vsp_core_state_t q; // Registered state
  vsp_core_state_t next_q; // Next state
  logic [4:0] limit_code; // Threshold code field
  logic [6:0] thr_sum; // 89 plus code, at most 120
  logic [2:0] need; // Periods required to raise the flag
  logic [2:0] run_inc; // Run length after one more exceeding period

  vsp_avg_if avg_bus (); // Link to the averager

  // Averaging window and comparison
  vsp_ov_avg #(
    .PERIOD_CYCLES(16'(PERIOD_CYCLES))
  ) u_avg (
    .ref_clk(ref_clk),
    .rst(rst),
    .local_sense_raw(local_sense_raw),
    .local_sense_raw_valid(local_sense_raw_valid),
    .ifc(avg_bus.avg)
  );

  // Field decode shared by the next-state logic
  always_comb begin
    limit_code = q.limit[vsp_pkg::LIMIT_CODE_MSB:vsp_pkg::LIMIT_CODE_LSB];
    thr_sum = vsp_pkg::THR_OFFSET + {2'b00, limit_code};
    need = {1'b0, q.limit[vsp_pkg::SAMPLES_MSB:vsp_pkg::SAMPLES_LSB]} + 3'h1;
    run_inc = q.run + 3'h1;
  end

  // Register access, setpoint staging and overvoltage qualifier
  always_comb begin
    next_q = q;

    // Threshold in 12-bit sense codes: (89 + code) * 4096 / 128
    next_q.thr = {thr_sum, {vsp_pkg::THR_FRAC_W{1'b0}}};

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        vsp_pkg::ADDR_SETPOINT: begin
          // Only the shadow moves; regulation keeps its value
          next_q.shadow = reg_wdata;
        end
        vsp_pkg::ADDR_OV_LIMIT: begin
          // Whole byte stored, spare bit included
          next_q.limit = reg_wdata;
        end
        vsp_pkg::ADDR_COMMIT: begin
          // Commit bit latches the staged code; the bit itself self-clears
          if (reg_wdata[vsp_pkg::COMMIT_BIT]) begin
            next_q.active = q.shadow;
          end
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end

    // Register reads, answered on the next edge
    if (reg_rd) begin
      unique case (reg_addr)
        vsp_pkg::ADDR_SETPOINT: begin
          next_q.rdata = q.shadow;
        end
        vsp_pkg::ADDR_OV_LIMIT: begin
          next_q.rdata = q.limit;
        end
        default: begin
          // Commit bit and unmapped offsets read as zero
          next_q.rdata = 8'h00;
        end
      endcase
    end

    // Consecutive-period qualifier, stepped once per finished window
    unique case (q.st)
      vsp_pkg::VSP_OV_CLEAR: begin
        if (avg_bus.done && avg_bus.over) begin
          next_q.run = 3'h1;
          if (need == 3'h1) begin
            // Single-period mode trips at once
            next_q.st = vsp_pkg::VSP_OV_TRIP;
            next_q.flag = 1'b1;
          end else begin
            next_q.st = vsp_pkg::VSP_OV_COUNT;
          end
        end
      end
      vsp_pkg::VSP_OV_COUNT: begin
        if (avg_bus.done) begin
          if (avg_bus.over) begin
            next_q.run = run_inc;
            if (run_inc >= need) begin
              // Every configured period was above threshold
              next_q.st = vsp_pkg::VSP_OV_TRIP;
              next_q.flag = 1'b1;
            end
          end else begin
            // A quiet period breaks the run
            next_q.run = 3'h0;
            next_q.st = vsp_pkg::VSP_OV_CLEAR;
          end
        end
      end
      vsp_pkg::VSP_OV_TRIP: begin
        if (avg_bus.done && !avg_bus.over) begin
          // Flag drops with the first period not strictly above threshold
          next_q.run = 3'h0;
          next_q.st = vsp_pkg::VSP_OV_CLEAR;
          next_q.flag = 1'b0;
        end
      end
      default: begin
        // Illegal code recovers to clear
        next_q.run = 3'h0;
        next_q.st = vsp_pkg::VSP_OV_CLEAR;
        next_q.flag = 1'b0;
      end
    endcase
  end

  // State register; setpoint starts at the nominal code
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q.shadow <= vsp_pkg::SETPOINT_RESET;
      q.active <= vsp_pkg::SETPOINT_RESET;
      q.limit <= vsp_pkg::OV_LIMIT_RESET;
      q.thr <= {vsp_pkg::THR_OFFSET, {vsp_pkg::THR_FRAC_W{1'b0}}};
      q.run <= 3'h0;
      q.st <= vsp_pkg::VSP_OV_CLEAR;
      q.flag <= 1'b0;
      q.rdata <= 8'h00;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flip-flops
  assign avg_bus.thr = q.thr;
  assign reg_rdata = q.rdata;
  assign active_setpoint = q.active;
  assign ov_threshold = q.thr;
  assign ov_flag = q.flag;

endmodule

`default_nettype wire

//--- rtl/vsp_ov_avg.sv
`timescale 1ns/1ps
`default_nettype none

module vsp_ov_avg #(
  parameter logic [15:0] PERIOD_CYCLES = 16'h3e80 // Window length in clocks
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [11:0] local_sense_raw, // Local sense sample
  input wire logic local_sense_raw_valid, // Sample strobe
  vsp_avg_if.avg ifc // Threshold in, period result out
);

  typedef struct packed {
    logic [15:0] cnt; // Clocks elapsed in this window
    logic [27:0] sum; // Sum of samples in this window
    logic [15:0] num; // Number of samples in this window
    logic done; // End-of-window pulse
    logic over; // Result of the last window
  } vsp_avg_state_t;

  vsp_avg_state_t q; // Registered state
  vsp_avg_state_t next_q; // Next state
  logic [27:0] sum_now; // Sum including this cycle's sample
  logic [15:0] num_now; // Count including this cycle's sample
  logic [27:0] limit; // Threshold times sample count

  // Accumulate over a fixed window and compare sum against threshold*count,
  // which equals comparing the average without a divider
  always_comb begin
    next_q = q;
    sum_now = q.sum + (local_sense_raw_valid ? {16'h0000, local_sense_raw} : 28'h000_0000);
    num_now = q.num + {15'h0000, local_sense_raw_valid};
    limit = {16'h0000, ifc.thr} * {12'h000, num_now};
    next_q.done = 1'b0;
    if (q.cnt == PERIOD_CYCLES - 16'h0001) begin
      // Window closes: strictly greater counts as exceeding
      next_q.over = (num_now != 16'h0000) && (sum_now > limit);
      next_q.done = 1'b1;
      next_q.cnt = 16'h0000;
      next_q.sum = 28'h000_0000;
      next_q.num = 16'h0000;
    end else begin
      // Window still open
      next_q.cnt = q.cnt + 16'h0001;
      next_q.sum = sum_now;
      next_q.num = num_now;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ifc.done = q.done;
  assign ifc.over = q.over;

endmodule

`default_nettype wire

//--- rtl/vsp_pkg.sv
package vsp_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_SETPOINT = 8'h31;
  localparam logic [7:0] ADDR_OV_LIMIT = 8'h32;
  localparam logic [7:0] ADDR_COMMIT = 8'h5d;

  // Field positions
  localparam int COMMIT_BIT = 0;
  localparam int LIMIT_CODE_MSB = 7;
  localparam int LIMIT_CODE_LSB = 3;
  localparam int LIMIT_SPARE_BIT = 2;
  localparam int SAMPLES_MSB = 1;
  localparam int SAMPLES_LSB = 0;

  // Reset values
  localparam logic [7:0] SETPOINT_RESET = 8'ha5;
  localparam logic [7:0] OV_LIMIT_RESET = 8'h00;

  // Threshold arithmetic: (89 + code) / 128 of a 12-bit 1.55 V full scale
  localparam int SENSE_W = 12;
  localparam logic [6:0] THR_OFFSET = 7'h59;
  localparam int THR_FRAC_W = 5;

  // Averaging window: 80 us at 200 MHz
  localparam int CLK_FREQ_MHZ = 200;
  localparam int OV_PERIOD_NS = 80000;
  localparam int OV_PERIOD_CYC = (OV_PERIOD_NS * CLK_FREQ_MHZ) / 1000;

  // Consecutive-period qualifier states
  typedef enum logic [1:0] {
    VSP_OV_CLEAR = 2'b00,
    VSP_OV_COUNT = 2'b01,
    VSP_OV_TRIP = 2'b10
  } vsp_ov_state_t;

endpackage

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Register and overvoltage bench for the core
module tb_top;
  localparam int P = 16; // Short window
  localparam logic [11:0] HI = 12'h0b21; // Just above code-0 threshold
  localparam logic [11:0] EQ = 12'h0b20; // On threshold
  localparam logic [11:0] LO = 12'h0100; // Far below
  logic ref_clk, rst, reg_wr, reg_rd, local_sense_raw_valid, ov_flag; // Controls
  logic [7:0] reg_addr, reg_wdata, reg_rdata, active_setpoint; // Byte signals
  logic [11:0] local_sense_raw, ov_threshold; // Sense and threshold
  logic [4:0] codes [4] = '{5'h00, 5'h0a, 5'h14, 5'h1f}; // Limit codes
  int error_cnt = 0; // Mismatches
  int num_checks = 0; // Comparisons
  int cyc; // Edges since release
  vsp_core #(.PERIOD_CYCLES(P)) uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .local_sense_raw(local_sense_raw), .local_sense_raw_valid(local_sense_raw_valid),
    .active_setpoint(active_setpoint), .ov_threshold(ov_threshold), .ov_flag(ov_flag));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Edge count aligns windows
  always @(posedge ref_clk or posedge rst) begin
    cyc <= rst ? 0 : cyc + 1;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(negedge ref_clk);
  endtask
  // One window of steady input; checks flag left by the windows before
  task automatic win(input logic [11:0] v, input logic vld, input logic exp);
    while (cyc % P != 0) @(negedge ref_clk);
    local_sense_raw = v;
    local_sense_raw_valid = vld;
    repeat (2) @(negedge ref_clk);
    chk(ov_flag, exp);
    repeat (P - 2) @(negedge ref_clk);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    local_sense_raw = 12'h0000;
    local_sense_raw_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    chk(active_setpoint, 8'ha5);
    chk(ov_threshold, 12'h0b20);
    rd(8'h31, 8'ha5);
    wr(8'h31, 8'h3c);
    wr(8'h5d, 8'h01);
    wr(8'h31, 8'h5a);
    rd(8'h31, 8'h5a);
    chk(active_setpoint, 8'h3c);
    wr(8'h5d, 8'hfe);
    rd(8'h5d, 8'h00);
    chk(active_setpoint, 8'h3c);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    wr(8'h5d, 8'h01);
    idle();
    chk(active_setpoint, 8'h5a);
    foreach (codes[k]) begin
      wr(8'h32, {codes[k], 3'b110});
      rd(8'h32, {codes[k], 3'b110});
      chk(ov_threshold, 12'((89 + codes[k]) * 32));
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h32, 8'(m));
      idle();
      win(LO, 1'b1, 1'b0);
      for (int i = 0; i < m; i++) win(HI, 1'b1, 1'b0);
      win(LO, 1'b1, 1'b0);
      for (int i = 0; i <= m; i++) win(HI, 1'b1, 1'b0);
      win(EQ, 1'b1, 1'b1);
      win(HI, 1'b0, 1'b0);
      win(LO, 1'b1, 1'b0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- sim/vsp_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches register effects and flag timing of the core
module vsp_core_chk #(
  parameter int PERIOD_CYCLES = 16 // Window length in clocks
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [11:0] local_sense_raw, // Sample
  input wire logic local_sense_raw_valid, // Sample strobe
  input wire logic [7:0] active_setpoint, // Active setpoint
  input wire logic [11:0] ov_threshold, // Threshold
  input wire logic ov_flag // Flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  int ph; // Edges since release, modulo the window
  wire logic wr_sp = reg_wr && reg_addr == 8'h31; // Setpoint write
  wire logic wr_lim = reg_wr && reg_addr == 8'h32; // Limit write
  wire logic go = reg_wr && reg_addr == 8'h5d && reg_wdata[0]; // Commit
  // Window phase tracker
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph <= 0;
    end else begin
      ph <= (ph == PERIOD_CYCLES - 1) ? 0 : ph + 1;
    end
  end
  property p_shadow_only; wr_sp |=> $stable(active_setpoint); endproperty
  a_shadow_only: assert property (p_shadow_only) else $error("setpoint write moved active value");
  property p_needs_go; !$stable(active_setpoint) |-> $past(go); endproperty
  a_needs_go: assert property (p_needs_go) else $error("active setpoint moved without commit");
  property p_go_val; wr_sp ##1 go |=> active_setpoint == $past(reg_wdata, 2); endproperty
  a_go_val: assert property (p_go_val) else $error("commit did not apply shadow");
  property p_go_rd; reg_rd && reg_addr == 8'h5d |=> reg_rdata == 8'h00; endproperty
  a_go_rd: assert property (p_go_rd) else $error("commit bit read not zero");
  property p_sp_rd; wr_sp ##1 (reg_rd && reg_addr == 8'h31) |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_sp_rd: assert property (p_sp_rd) else $error("shadow readback wrong");
  property p_lim_rd; wr_lim ##1 (reg_rd && reg_addr == 8'h32) |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_lim_rd: assert property (p_lim_rd) else $error("limit readback wrong");
  property p_thr;
    wr_lim ##1 !wr_lim |=> ov_threshold == {7'(7'h59 + 7'($past(reg_wdata[7:3], 2))), 5'h00};
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode wrong");
  property p_flag_phase; $changed(ov_flag) |-> ph == 1; endproperty
  a_flag_phase: assert property (p_flag_phase) else $error("flag moved off window close");
  c_flag: cover property ($rose(ov_flag));
  c_go: cover property (wr_sp ##1 go);
  c_lim: cover property (wr_lim ##1 reg_rd);
endmodule
bind vsp_core vsp_core_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .local_sense_raw(local_sense_raw), .local_sense_raw_valid(local_sense_raw_valid),
  .active_setpoint(active_setpoint), .ov_threshold(ov_threshold), .ov_flag(ov_flag));
`default_nettype wire
